// *** logic/i2c_start_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "i2c_start_defs.svh"

module i2c_start_gen #(
  parameter int BAUD_W = 7,
  parameter int DIV    = `INSTR_DIV
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOeN,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOeN,
  output logic             irq
);

  // ***********************************************************************
  // State
  // ***********************************************************************
  i2c_start_pkg::start_state_t state_ff;
  i2c_start_pkg::start_state_t nxt_state;
  i2c_start_pkg::evt_vec_t     evt_ff;
  i2c_start_pkg::evt_vec_t     nxt_evt;
  i2c_start_pkg::evt_vec_t     evtEn_ff;
  i2c_start_pkg::evt_vec_t     nxt_evtEn;
  i2c_start_pkg::evt_vec_t     evtSet;
  i2c_start_pkg::evt_vec_t     evtClr;

  logic [7:0]        ctrl2_ff;
  logic [7:0]        nxt_ctrl2;
  logic [BAUD_W-1:0] baud_ff;
  logic [BAUD_W-1:0] nxt_baud;
  logic [7:0]        xbuf_ff;
  logic [7:0]        nxt_xbuf;
  logic              startSeen_ff;
  logic              nxt_startSeen;
  logic              sdaOeN_ff;
  logic              nxt_sdaOeN;
  logic              ack_ff;
  logic              nxt_ack;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic              irq_ff;
  logic              nxt_irq;

  logic sdaMeta_ff;
  logic sdaSync_ff;
  logic sclMeta_ff;
  logic sclSync_ff;

  logic busReq;
  logic wrLow;
  logic busy;
  logic doLoad;
  logic doHalt;

  baud_if #(.W(BAUD_W)) bif ();

  baud_gen #(
    .W   (BAUD_W),
    .DIV (DIV)
  ) u_baud (
    .core_clk (core_clk),
    .rst      (rst),
    .bus      (bif)
  );

  assign bif.load      = doLoad;
  assign bif.halt      = doHalt;
  assign bif.reloadVal = baud_ff;

  // ***********************************************************************
  // Pin synchronisers
  // ***********************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sdaMeta_ff <= 1'b1;
      sdaSync_ff <= 1'b1;
      sclMeta_ff <= 1'b1;
      sclSync_ff <= 1'b1;
    end else begin
      sdaMeta_ff <= sdaIn;
      sdaSync_ff <= sdaMeta_ff;
      sclMeta_ff <= sclIn;
      sclSync_ff <= sclMeta_ff;
    end
  end

  // ***********************************************************************
  // Next-state logic: bus slave, sequencer, events
  // ***********************************************************************
  always_comb begin
    busReq        = wb_cyc_i && wb_stb_i && !ack_ff;
    wrLow         = busReq && wb_we_i && wb_sel_i[0];
    busy          = ctrl2_ff[`START_REQ_BIT] || (state_ff != i2c_start_pkg::ST_IDLE);
    nxt_state     = state_ff;
    nxt_ctrl2     = ctrl2_ff;
    nxt_baud      = baud_ff;
    nxt_xbuf      = xbuf_ff;
    nxt_evtEn     = evtEn_ff;
    nxt_startSeen = startSeen_ff;
    nxt_sdaOeN    = sdaOeN_ff;
    nxt_ack       = busReq;
    nxt_rdata     = '0;
    evtSet        = '0;
    evtClr        = '0;
    doLoad        = 1'b0;
    doHalt        = 1'b0;

    // Register writes
    if (wrLow) begin
      unique case (wb_adr_i)
        `OFF_CTRL2: begin
          if (busy) begin
            nxt_ctrl2[7:`CTRL2_LOCK_W] = wb_dat_i[7:`CTRL2_LOCK_W];
          end else begin
            nxt_ctrl2 = wb_dat_i[7:0];
          end
        end
        `OFF_BAUD: begin
          nxt_baud = wb_dat_i[BAUD_W-1:0];
        end
        `OFF_XBUF: begin
          if (busy) begin
            evtSet[`EVT_WRITE_COLLISION_FLAG_BIT] = 1'b1;
          end else begin
            nxt_xbuf = wb_dat_i[7:0];
          end
        end
        `OFF_EVT_EN: begin
          nxt_evtEn = wb_dat_i[2:0];
        end
        `OFF_EVT_CLR: begin
          evtClr = wb_dat_i[2:0];
        end
        `OFF_LINE: begin
          // Releasing the held SDA is only honoured between sequences
          if (wb_dat_i[`LINE_REL_BIT] && !busy) begin
            nxt_sdaOeN = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads; unmapped offsets answer zero
    if (busReq && !wb_we_i) begin
      unique case (wb_adr_i)
        `OFF_CTRL2:  nxt_rdata[7:0] = ctrl2_ff;
        `OFF_STATUS: nxt_rdata[`START_SEEN_BIT] = startSeen_ff;
        `OFF_BAUD:   nxt_rdata[BAUD_W-1:0] = baud_ff;
        `OFF_XBUF:   nxt_rdata[7:0] = xbuf_ff;
        `OFF_EVT:    nxt_rdata[2:0] = evt_ff;
        `OFF_EVT_EN: nxt_rdata[2:0] = evtEn_ff;
        `OFF_LINE:   nxt_rdata[2:0] = {sclSync_ff, sdaSync_ff, !sdaOeN_ff};
        default:     nxt_rdata = '0;
      endcase
    end

    // Start sequencer
    unique case (state_ff)
      i2c_start_pkg::ST_IDLE: begin
        if (ctrl2_ff[`START_REQ_BIT]) begin
          nxt_startSeen = 1'b0;
          nxt_state     = i2c_start_pkg::ST_CHECK;
        end
      end
      i2c_start_pkg::ST_CHECK: begin
        if (!sclSync_ff) begin
          // Covers both lines low as well as SCL alone low
          evtSet[`EVT_BCOL_BIT]       = 1'b1;
          nxt_ctrl2[`START_REQ_BIT]   = 1'b0;
          nxt_state                   = i2c_start_pkg::ST_IDLE;
        end else if (sdaSync_ff) begin
          doLoad    = 1'b1;
          nxt_state = i2c_start_pkg::ST_HOLD;
        end
      end
      i2c_start_pkg::ST_HOLD: begin
        if (!sclSync_ff || (bif.timeout && !sdaSync_ff)) begin
          evtSet[`EVT_BCOL_BIT]     = 1'b1;
          nxt_ctrl2[`START_REQ_BIT] = 1'b0;
          doHalt                    = 1'b1;
          nxt_state                 = i2c_start_pkg::ST_IDLE;
        end else if (bif.timeout) begin
          nxt_sdaOeN    = 1'b0;
          nxt_startSeen = 1'b1;
          doLoad        = 1'b1;
          nxt_state     = i2c_start_pkg::ST_TAIL;
        end
      end
      i2c_start_pkg::ST_TAIL: begin
        if (bif.timeout) begin
          // SDA stays driven low for the address phase that follows
          nxt_ctrl2[`START_REQ_BIT] = 1'b0;
          doHalt                    = 1'b1;
          evtSet[`EVT_DONE_BIT]     = 1'b1;
          nxt_state                 = i2c_start_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = i2c_start_pkg::ST_IDLE;
      end
    endcase

    // Set wins over a clear landing in the same cycle
    nxt_evt = (evt_ff & ~evtClr) | evtSet;
    nxt_irq = |(nxt_evt & nxt_evtEn);
  end

  // ***********************************************************************
  // Registers
  // ***********************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff     <= i2c_start_pkg::ST_IDLE;
      ctrl2_ff     <= `CTRL2_RESET;
      baud_ff      <= `BAUD_RESET;
      xbuf_ff      <= `XBUF_RESET;
      evt_ff       <= `EVT_RESET;
      evtEn_ff     <= `EVT_RESET;
      startSeen_ff <= 1'b0;
      sdaOeN_ff    <= 1'b1;
      ack_ff       <= 1'b0;
      rdata_ff     <= '0;
      irq_ff       <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      ctrl2_ff     <= nxt_ctrl2;
      baud_ff      <= nxt_baud;
      xbuf_ff      <= nxt_xbuf;
      evt_ff       <= nxt_evt;
      evtEn_ff     <= nxt_evtEn;
      startSeen_ff <= nxt_startSeen;
      sdaOeN_ff    <= nxt_sdaOeN;
      ack_ff       <= nxt_ack;
      rdata_ff     <= nxt_rdata;
      irq_ff       <= nxt_irq;
    end
  end

  // ***********************************************************************
  // Outputs
  // ***********************************************************************
  assign wb_dat_o = rdata_ff;
  assign wb_ack_o = ack_ff;
  assign irq      = irq_ff;
  assign sdaOeN   = sdaOeN_ff;
  // Open-drain: only ever pulls low; SCL is never driven during a Start
  assign sdaOut   = 1'b0;
  assign sclOut   = 1'b0;
  assign sclOeN   = 1'b1;

endmodule

`default_nettype wire

// *** logic/i2c_start_defs.svh ***
`ifndef I2C_START_DEFS_SVH
`define I2C_START_DEFS_SVH

// ***********************************************************************
// Register byte offsets
// ***********************************************************************
`define OFF_CTRL2      8'h00
`define OFF_STATUS     8'h04
`define OFF_BAUD       8'h08
`define OFF_XBUF       8'h0c
`define OFF_EVT        8'h10
`define OFF_EVT_EN     8'h14
`define OFF_EVT_CLR    8'h18
`define OFF_LINE       8'h1c

// ***********************************************************************
// Field positions
// ***********************************************************************
`define START_REQ_BIT  0
`define START_SEEN_BIT 3
`define CTRL2_LOCK_W   5
`define EVT_BCOL_BIT   0
`define EVT_WRITE_COLLISION_FLAG_BIT   1
`define EVT_DONE_BIT   2
`define LINE_REL_BIT   0

// ***********************************************************************
// Reset values and timing
// ***********************************************************************
`define CTRL2_RESET    8'h00
`define BAUD_RESET     7'h00
`define XBUF_RESET     8'h00
`define EVT_RESET      3'h0
`define INSTR_DIV      4

`endif

// *** logic/i2c_start_pkg.sv ***
package i2c_start_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_HOLD  = 4'b0100,
    ST_TAIL  = 4'b1000
  } start_state_t;

  typedef logic [2:0] evt_vec_t;

endpackage

// *** logic/baud_if.sv ***
`timescale 1ns/1ns
`default_nettype none

interface baud_if #(parameter int W = 7);
  logic         load;
  logic         halt;
  logic [W-1:0] reloadVal;
  logic         timeout;

  modport ctrl (output load, output halt, output reloadVal, input timeout);
  modport gen  (input load, input halt, input reloadVal, output timeout);
endinterface

`default_nettype wire

// *** logic/baud_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "i2c_start_defs.svh"

module baud_gen #(
  parameter int W   = 7,
  parameter int DIV = `INSTR_DIV
) (
  input wire logic core_clk,
  input wire logic rst,
  baud_if.gen      bus
);

  localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

  logic [DW-1:0] divCnt_ff;
  logic [DW-1:0] nxt_divCnt;
  logic [W-1:0]  cnt_ff;
  logic [W-1:0]  nxt_cnt;
  logic          run_ff;
  logic          nxt_run;
  logic          timeout_ff;
  logic          nxt_timeout;
  logic          tick;

  // ***********************************************************************
  // Instruction-cycle enable and down counter
  // ***********************************************************************
  always_comb begin
    tick        = (divCnt_ff == DIV_LAST);
    nxt_divCnt  = tick ? '0 : divCnt_ff + DW'(1);
    nxt_cnt     = cnt_ff;
    nxt_run     = run_ff;
    nxt_timeout = 1'b0;
    if (bus.load) begin
      // Divider restarts so every period is exactly (reload+1)*DIV+1 cycles from load to timeout
      nxt_divCnt = '0;
      nxt_cnt    = bus.reloadVal;
      nxt_run    = 1'b1;
    end else if (bus.halt) begin
      nxt_run = 1'b0;
    end else if (run_ff && tick) begin
      if (cnt_ff == '0) begin
        nxt_timeout = 1'b1;
        nxt_run     = 1'b0;
      end else begin
        nxt_cnt = cnt_ff - W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      divCnt_ff  <= '0;
      cnt_ff     <= '0;
      run_ff     <= 1'b0;
      timeout_ff <= 1'b0;
    end else begin
      divCnt_ff  <= nxt_divCnt;
      cnt_ff     <= nxt_cnt;
      run_ff     <= nxt_run;
      timeout_ff <= nxt_timeout;
    end
  end

  assign bus.timeout = timeout_ff;

endmodule

`default_nettype wire

// *** dv/i2c_bus_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// **********
// Open-drain bus with pull-ups
// **********
module i2c_bus_model (
  input  wire logic sdaOeN,
  input  wire logic sclOeN,
  input  wire logic holdSda,
  input  wire logic holdScl,
  output logic      sda,
  output logic      scl
);
  // A released line floats up to the pull-up, never to a stale value
  assign sda = sdaOeN & ~holdSda;
  assign scl = sclOeN & ~holdScl;
endmodule
`default_nettype wire

// *** dv/i2c_start_gen_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module i2c_start_gen_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sclIn,
  input wire logic        sdaOut,
  input wire logic        sdaOeN,
  input wire logic        sclOeN,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic req;
  logic relWr;
  assign req   = wb_cyc_i && wb_stb_i;
  assign relWr = req && wb_we_i && wb_adr_i == 8'h1c && wb_sel_i[0] && wb_dat_i[0];
  ack_timely_a: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(req)) else $error("ack unasked");
  rdata_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
  scl_left_high_a: assert property (sclOeN) else $error("scl driven");
  sda_open_drain_a: assert property (sdaOut == 1'b0) else $error("sda drives high");
  start_scl_high_a: assert property ($fell(sdaOeN) |-> $past(sclIn)) else $error("start with scl low");
  sda_kept_low_a: assert property ($rose(sdaOeN) && !$past(rst) |-> $past(relWr))
    else $error("sda let go");
  cover property ($fell(sdaOeN));
  cover property ($rose(irq));
  cover property (wb_ack_o && !wb_we_i);
endmodule
bind i2c_start_gen i2c_start_gen_checker chk (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sclIn, .sdaOut, .sdaOeN, .sclOeN, .irq);
`default_nettype wire

// *** dv/i2c_master_start_generator_test.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "i2c_start_defs.svh"
module i2c_master_start_generator_test;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] datO, rd;
  logic        ack, sda, scl, sdaOut, sdaOeN, sclOut, sclOeN, irq, oeQ, irqQ;
  logic        holdSda = 1'b0;
  logic        holdScl = 1'b0;
  int          nCyc = 0;
  int          tFall, tIrq, t0, errTotal, nTests;
  logic [7:0]  offs [6] = '{`OFF_CTRL2, `OFF_STATUS, `OFF_XBUF, `OFF_EVT, `OFF_EVT_CLR, 8'h20};
  always #25 core_clk = ~core_clk;
  i2c_start_gen dut (.core_clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack), .sdaIn(sda), .sdaOut, .sdaOeN,
    .sclIn(scl), .sclOut, .sclOeN, .irq);
  i2c_bus_model bus (.sdaOeN, .sclOeN, .holdSda, .holdScl, .sda, .scl);
  // Edge stamps let the baud periods be measured without polling inside the tests
  always @(posedge core_clk) begin
    nCyc <= nCyc + 1;
    oeQ <= sdaOeN;
    irqQ <= irq;
    if (sdaOeN === 1'b0 && oeQ === 1'b1) tFall <= nCyc;
    if (irq === 1'b1 && irqQ === 1'b0) tIrq <= nCyc;
  end
  // **********
  // Bus and compare tasks
  // **********
  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do @(posedge core_clk); while (ack !== 1'b1);
    rd = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // **********
  // Tests
  // **********
  task automatic testRegs;
    foreach (offs[i]) rchk(offs[i], 32'h0);
    wb(1'b1, `OFF_BAUD, 8'hff);
    rchk(`OFF_BAUD, 32'h7f);
    $display("test regs done");
  endtask
  task automatic testStart;
    wb(1'b1, `OFF_BAUD, 8'h02);
    wb(1'b1, `OFF_EVT_EN, 8'h04);
    wb(1'b1, `OFF_CTRL2, 8'h01);
    t0 = nCyc;
    wb(1'b1, `OFF_XBUF, 8'h5a);
    wb(1'b1, `OFF_CTRL2, 8'hfe);
    for (int k = 0; k < 200 && irq !== 1'b1; k++) @(posedge core_clk);
    // The edge stamp for irq lands by NBA in the same step the loop exits
    ticks(1);
    chk({31'h0, (tFall - t0) inside {[12:18]}}, 32'h1);
    chk({31'h0, (tIrq - tFall) inside {[12:14]}}, 32'h1);
    chk(sdaOeN, 32'h0);
    rchk(`OFF_STATUS, 32'h8);
    rchk(`OFF_CTRL2, 32'he0);
    rchk(`OFF_XBUF, 32'h0);
    rchk(`OFF_EVT, 32'h6);
    wb(1'b1, `OFF_EVT_CLR, 8'h07);
    rchk(`OFF_EVT, 32'h0);
    chk(irq, 32'h0);
    wb(1'b1, `OFF_LINE, 8'h01);
    chk(sdaOeN, 32'h1);
    wb(1'b1, `OFF_CTRL2, 8'h00);
    $display("test start done");
  endtask
  task automatic testCollEarly;
    holdSda <= 1'b1;
    holdScl <= 1'b1;
    wb(1'b1, `OFF_EVT_EN, 8'h01);
    wb(1'b1, `OFF_CTRL2, 8'h01);
    ticks(8);
    chk(irq, 32'h1);
    rchk(`OFF_EVT, 32'h1);
    rchk(`OFF_CTRL2, 32'h0);
    chk(sdaOeN, 32'h1);
    holdSda <= 1'b0;
    holdScl <= 1'b0;
    wb(1'b1, `OFF_EVT_CLR, 8'h01);
    $display("test early collision done");
  endtask
  task automatic testCollScl;
    wb(1'b1, `OFF_CTRL2, 8'h01);
    ticks(6);
    holdScl <= 1'b1;
    ticks(20);
    holdScl <= 1'b0;
    rchk(`OFF_EVT, 32'h1);
    rchk(`OFF_CTRL2, 32'h0);
    chk(sdaOeN, 32'h1);
    $display("test scl collision done");
  endtask
  initial begin
    ticks(2);
    rst <= 1'b0;
    testRegs;
    testStart;
    testCollEarly;
    testCollScl;
    endOfTest;
  end
  initial begin
    ticks(3000);
    errTotal++;
    endOfTest;
  end
endmodule
`default_nettype wire
